// ===== inc/shci_pkg.sv
/*
 * Shared constants and types of the serial host command interface:
 * address and subaddress codes, status patterns, control byte fields,
 * write destinations and the write request carrier.
 * Assumes nothing of its surroundings; no clocks or logic in here.
 */
package shci_pkg;

    // ************************************************************
    // bus addressing
    // ************************************************************
    localparam logic [5:0] I2C_ADDR_HI = 6'h1c;
    localparam int I2C_SEL_BIT = 1;
    localparam int I2C_RW_BIT = 0;
    localparam logic [1:0] SPI_SUBADDR = 2'h1;
    localparam int SPI_RW_BIT = 7;
    localparam int SUBADDR_HI = 6;
    localparam int SUBADDR_LO = 5;

    // ************************************************************
    // status read-back
    // ************************************************************
    // identification pattern: value is arbitrary
    localparam logic [6:0] STATUS_ID = 7'h3c;
    localparam logic [6:0] STATUS_TEST = 7'h78;

    // ************************************************************
    // control byte and byte framing
    // ************************************************************
    localparam int CONT_BIT = 7;
    localparam int DEST_HI = 6;
    localparam int DEST_LO = 5;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] SPI_LAST_BIT = 3'h7;
    localparam int PTR_W = 8;
    localparam int SYNC_W = 6;

    typedef enum logic [1:0] {
        DEST_CMD = 2'h0,
        DEST_RAM = 2'h1,
        DEST_PWM = 2'h2,
        DEST_NONE = 2'h3
    } dest_t;

    typedef struct packed {
        dest_t dest;
        logic [PTR_W-1:0] addr;
        logic [7:0] data;
    } wr_t;

endpackage : shci_pkg

// ===== design/shci_sync.sv
/*
 * Two-stage level synchroniser, a vector of independent bits.
 * Assumes each bit is a slow level or a toggle; no word coherency.
 */
`timescale 1ns/10ps
`default_nettype none

module shci_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= '0;
            o_sync <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end

endmodule : shci_sync

`default_nettype wire

// ===== design/shci_spi_rx.sv
/*
 * Receive-only SPI front end running on the serial clock.
 * Checks the subaddress byte, then, if it is accepted, hands each later
 * byte to the system domain as a held word plus a toggle.
 * Assumes the host returns select high between transfers and the
 * system clock is several times faster than the serial clock.
 */
`timescale 1ns/10ps
`default_nettype none

module shci_spi_rx (
    input wire logic i_spi_clk,
    input wire logic i_rst_n,
    input wire logic i_spi_cs_n,
    input wire logic i_serial_in_line,
    output logic [7:0] o_byte,
    output logic o_byte_tgl
);

    typedef enum {SPI_HDR, SPI_DATA, SPI_SKIP} spi_state_t;

    spi_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic [7:0] byte_next;

    assign byte_next = {shift_reg, i_serial_in_line};

    // ************************************************************
    // framing, cleared whenever select is high
    // ************************************************************
    always_ff @(posedge i_spi_clk or posedge i_spi_cs_n) begin
        if (i_spi_cs_n) begin
            state_reg <= SPI_HDR;
            bit_cnt_reg <= '0;
            shift_reg <= '0;
        end else begin
            shift_reg <= byte_next[6:0];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == shci_pkg::SPI_LAST_BIT) begin
                case (state_reg)
                    SPI_HDR: begin
                        // read requests have no line to answer on
                        if (byte_next[shci_pkg::SUBADDR_HI:shci_pkg::SUBADDR_LO]
                                == shci_pkg::SPI_SUBADDR
                                && !byte_next[shci_pkg::SPI_RW_BIT]) begin
                            state_reg <= SPI_DATA;
                        end else begin
                            state_reg <= SPI_SKIP;
                        end
                    end
                    SPI_DATA: state_reg <= SPI_DATA;
                    SPI_SKIP: state_reg <= SPI_SKIP;
                    default: state_reg <= SPI_SKIP;
                endcase
            end
        end
    end

    // ************************************************************
    // hand-off word; not cleared by select so the toggle never glitches
    // ************************************************************
    always_ff @(posedge i_spi_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_byte <= '0;
            o_byte_tgl <= 1'b0;
        end else if (bit_cnt_reg == shci_pkg::SPI_LAST_BIT && state_reg == SPI_DATA
                && !i_spi_cs_n) begin
            o_byte <= byte_next;
            o_byte_tgl <= ~o_byte_tgl;
        end
    end

endmodule : shci_spi_rx

`default_nettype wire

// ===== design/shci_top.sv
/*
 * Serial host command interface: I2C slave receiver with status
 * read-back, and an SPI receive path, both feeding one control byte
 * parser that routes data to command, display memory or PWM store.
 * Assumes i_use_spi is a strap, the memory pointers are kept by the
 * consumer of o_wr, and the serial clock is at most an eighth of
 * the system clock.
 */
`timescale 1ns/10ps
`default_nettype none

// Contract
// - acknowledge address only when its select bit equals the strapped pin
// - on select mismatch ignore every byte until next START or STOP
// - I2C: first byte after acknowledged address is a control byte
// - display data bytes go to display memory at the display pointer
// - PWM data bytes go to the PWM store at the PWM pointer
// - only the addressed device pulls acknowledge low; others stay released
// - accept STOP or repeated START as end and restart address recognition
// - status byte: identification pattern in bits 7..1, strap in bit 0
// - read bit set in address makes device send status next
// - in test mode status bits 7..1 carry 1111 000
// - SPI path only receives; no status read-back there
// - SPI receiver held in reset while select is high
// - SPI input sampled on rising serial clock
// - SPI bytes whole, most significant bit first
// - first SPI byte after select is the subaddress
// - subaddress bit 7: 0 write, 1 read; bits 4..0 unused
// - subaddress bits 6..5 must be 01, else ignore until deselect
// - SPI: byte after accepted subaddress is a control byte
// - control bits 6..5 route data: command, display, PWM; 11 unused
// - control bit 7 set: another control byte after next data byte
// - address bit 1 compared with strapped pin, two devices per bus
module shci_top (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_use_spi,
    input wire logic i_test_mode,
    input wire logic i_address_select_pin,
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_spi_clk,
    input wire logic i_spi_cs_n,
    input wire logic i_serial_in_line,
    input wire logic [shci_pkg::PTR_W-1:0] i_ram_ptr,
    input wire logic [shci_pkg::PTR_W-1:0] i_pwm_ptr,
    output logic o_wr_valid,
    output shci_pkg::wr_t o_wr,
    output logic o_addressed
);

    typedef enum {
        I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_RX, I2C_RX_ACK,
        I2C_TX, I2C_TX_ACK, I2C_SKIP
    } i2c_state_t;

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [7:0] status_byte(input logic test, input logic sel);
        status_byte = {(test ? shci_pkg::STATUS_TEST : shci_pkg::STATUS_ID), sel};
    endfunction : status_byte

    function automatic logic [shci_pkg::PTR_W-1:0] dest_addr(input shci_pkg::dest_t d,
            input logic [shci_pkg::PTR_W-1:0] ram, input logic [shci_pkg::PTR_W-1:0] pwm);
        case (d)
            shci_pkg::DEST_RAM: dest_addr = ram;
            shci_pkg::DEST_PWM: dest_addr = pwm;
            default: dest_addr = '0;
        endcase
    endfunction : dest_addr

    // ************************************************************
    // reset release and input synchronisers
    // ************************************************************
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    logic [7:0] spi_byte;
    logic spi_tgl;
    logic [shci_pkg::SYNC_W-1:0] sync_out;
    logic scl_s;
    logic sda_s;
    logic sel_s;
    logic cs_n_s;
    logic tgl_s;
    logic use_spi_s;

    shci_sync #(.W(shci_pkg::SYNC_W)) u_sync (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n_reg),
        .i_async({~i_scl, ~i_sda_in, i_address_select_pin, ~i_spi_cs_n, spi_tgl, i_use_spi}),
        .o_sync(sync_out) // idle-high lines ride inverted, so reset equals idle
    );

    assign {scl_s, sda_s, sel_s, cs_n_s, tgl_s, use_spi_s} = sync_out ^ 6'h34;

    shci_spi_rx u_spi (
        .i_spi_clk(i_spi_clk),
        .i_rst_n(rst_n_reg),
        .i_spi_cs_n(i_spi_cs_n),
        .i_serial_in_line(i_serial_in_line),
        .o_byte(spi_byte),
        .o_byte_tgl(spi_tgl)
    );

    // ************************************************************
    // bus condition detection
    // ************************************************************
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic cs_n_prev_reg;
    logic tgl_prev_reg;

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            cs_n_prev_reg <= 1'b1;
            tgl_prev_reg <= 1'b0;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
            cs_n_prev_reg <= cs_n_s;
            tgl_prev_reg <= tgl_s;
        end
    end

    logic i2c_start;
    logic i2c_stop;
    logic scl_rise;
    logic scl_fall;
    logic spi_byte_evt;
    logic spi_frame;

    assign i2c_start = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    assign i2c_stop = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
    assign scl_rise = scl_s && !scl_prev_reg;
    assign scl_fall = !scl_s && scl_prev_reg;
    assign spi_byte_evt = use_spi_s && (tgl_s != tgl_prev_reg);
    assign spi_frame = use_spi_s && (cs_n_s != cs_n_prev_reg);

    // ************************************************************
    // I2C slave state machine
    // ************************************************************
    i2c_state_t i2c_state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] tx_sh_reg;
    logic rw_reg;
    logic mack_reg;
    logic i2c_byte_evt;
    logic [7:0] status_now;

    // rx byte is complete on the falling edge after its eighth bit
    assign i2c_byte_evt = !use_spi_s && scl_fall && i2c_state_reg == I2C_RX
        && bit_cnt_reg == shci_pkg::BYTE_BITS;
    assign status_now = status_byte(i_test_mode, sel_s);

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            i2c_state_reg <= I2C_IDLE;
            bit_cnt_reg <= '0;
            rx_sh_reg <= '0;
            tx_sh_reg <= '0;
            rw_reg <= 1'b0;
            mack_reg <= 1'b0;
            o_sda_oe <= 1'b0;
            o_sda_out <= 1'b0;
        end else if (use_spi_s) begin
            i2c_state_reg <= I2C_IDLE;
            o_sda_oe <= 1'b0;
        end else if (i2c_start) begin
            i2c_state_reg <= I2C_ADDR;
            bit_cnt_reg <= '0;
            o_sda_oe <= 1'b0;
        end else if (i2c_stop) begin
            i2c_state_reg <= I2C_IDLE;
            o_sda_oe <= 1'b0;
        end else begin
            case (i2c_state_reg)
                I2C_ADDR, I2C_RX: begin
                    if (scl_rise) begin
                        rx_sh_reg <= {rx_sh_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == shci_pkg::BYTE_BITS) begin
                        bit_cnt_reg <= '0;
                        if (i2c_state_reg == I2C_RX) begin
                            i2c_state_reg <= I2C_RX_ACK;
                            o_sda_oe <= 1'b1;
                        end else if (rx_sh_reg[7:2] == shci_pkg::I2C_ADDR_HI
                                && rx_sh_reg[shci_pkg::I2C_SEL_BIT] == sel_s) begin
                            i2c_state_reg <= I2C_ADDR_ACK;
                            rw_reg <= rx_sh_reg[shci_pkg::I2C_RW_BIT];
                            o_sda_oe <= 1'b1;
                        end else begin
                            i2c_state_reg <= I2C_SKIP;
                        end
                    end
                end
                I2C_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_reg) begin
                            i2c_state_reg <= I2C_TX;
                            tx_sh_reg <= status_now;
                            o_sda_oe <= ~status_now[7];
                            bit_cnt_reg <= 4'h1;
                        end else begin
                            i2c_state_reg <= I2C_RX;
                            o_sda_oe <= 1'b0;
                        end
                    end
                end
                I2C_RX_ACK: begin
                    if (scl_fall) begin
                        i2c_state_reg <= I2C_RX;
                        o_sda_oe <= 1'b0;
                    end
                end
                I2C_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == shci_pkg::BYTE_BITS) begin
                            i2c_state_reg <= I2C_TX_ACK;
                            o_sda_oe <= 1'b0;
                        end else begin
                            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                            o_sda_oe <= ~tx_sh_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                I2C_TX_ACK: begin
                    // master ack repeats the status byte; nack waits for start or stop
                    if (scl_rise) begin
                        mack_reg <= !sda_s;
                    end else if (scl_fall) begin
                        if (mack_reg) begin
                            i2c_state_reg <= I2C_TX;
                            tx_sh_reg <= status_now;
                            o_sda_oe <= ~status_now[7];
                            bit_cnt_reg <= 4'h1;
                        end else begin
                            i2c_state_reg <= I2C_SKIP;
                        end
                    end
                end
                I2C_SKIP: o_sda_oe <= 1'b0;
                I2C_IDLE: o_sda_oe <= 1'b0;
                default: begin
                    i2c_state_reg <= I2C_IDLE;
                    o_sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // control byte parser, shared by both paths
    // ************************************************************
    logic frame_start;
    logic byte_evt;
    logic [7:0] byte_in;
    logic expect_ctrl_reg;
    logic cont_reg;
    shci_pkg::dest_t dest_reg;

    // a start or stop on I2C, any select edge on SPI begins a new frame
    assign frame_start = (!use_spi_s && (i2c_start || i2c_stop)) || spi_frame;
    assign byte_evt = i2c_byte_evt || spi_byte_evt;
    assign byte_in = use_spi_s ? spi_byte : rx_sh_reg;

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            expect_ctrl_reg <= 1'b1;
            cont_reg <= 1'b0;
            dest_reg <= shci_pkg::DEST_NONE;
        end else if (frame_start) begin
            expect_ctrl_reg <= 1'b1;
        end else if (byte_evt) begin
            if (expect_ctrl_reg) begin
                cont_reg <= byte_in[shci_pkg::CONT_BIT];
                dest_reg <= shci_pkg::dest_t'(byte_in[shci_pkg::DEST_HI:shci_pkg::DEST_LO]);
                expect_ctrl_reg <= 1'b0;
            end else begin
                expect_ctrl_reg <= cont_reg;
            end
        end
    end

    // ************************************************************
    // write request output
    // ************************************************************
    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_wr_valid <= 1'b0;
            o_wr <= '0;
        end else begin
            // unused destination code drops the byte silently
            o_wr_valid <= byte_evt && !frame_start && !expect_ctrl_reg
                && dest_reg != shci_pkg::DEST_NONE;
            if (byte_evt && !frame_start && !expect_ctrl_reg
                    && dest_reg != shci_pkg::DEST_NONE) begin
                o_wr.dest <= dest_reg;
                o_wr.addr <= dest_addr(dest_reg, i_ram_ptr, i_pwm_ptr);
                o_wr.data <= byte_in;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_addressed <= 1'b0;
        end else begin
            o_addressed <= i2c_state_reg != I2C_IDLE && i2c_state_reg != I2C_ADDR
                && i2c_state_reg != I2C_SKIP;
        end
    end

endmodule : shci_top

`default_nettype wire

// ===== tb/shci_sva.sv
/*
 * Checker for shci_top: write strobe, write routing and bus quiet rules.
 * Assumes it is bound to shci_top and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none

module shci_sva (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_use_spi,
    input wire logic [shci_pkg::PTR_W-1:0] i_ram_ptr,
    input wire logic [shci_pkg::PTR_W-1:0] i_pwm_ptr,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic o_wr_valid,
    input wire shci_pkg::wr_t o_wr,
    input wire logic o_addressed
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);

    // ********************
    // sequences
    // ********************
    // strap passes two sync flops plus up to two more flops (state and output) before each output
    sequence spi_held;
        i_use_spi [*6];
    endsequence
    sequence ram_wr;
        o_wr_valid && o_wr.dest == shci_pkg::DEST_RAM;
    endsequence
    sequence pwm_wr;
        o_wr_valid && o_wr.dest == shci_pkg::DEST_PWM;
    endsequence

    // ********************
    // assertions
    // ********************
    a_sda_out_low: assert property (o_sda_out == 1'b0)
        else $error("data pin drives high");
    a_spi_no_ack: assert property (spi_held |-> !o_sda_oe)
        else $error("data pin driven in spi mode");
    a_spi_no_addr: assert property (spi_held |-> !o_addressed)
        else $error("addressed in spi mode");
    a_wr_one_cycle: assert property (o_wr_valid |=> !o_wr_valid)
        else $error("write strobe longer than one cycle");
    a_wr_dest_used: assert property (o_wr_valid |-> o_wr.dest != shci_pkg::DEST_NONE)
        else $error("write to unused destination");
    a_cmd_addr_zero: assert property (
        o_wr_valid && o_wr.dest == shci_pkg::DEST_CMD |-> o_wr.addr == 8'h00)
        else $error("command write with address");
    a_ram_at_ptr: assert property (ram_wr |-> o_wr.addr == $past(i_ram_ptr))
        else $error("display write off pointer");
    a_pwm_at_ptr: assert property (pwm_wr |-> o_wr.addr == $past(i_pwm_ptr))
        else $error("pwm write off pointer");
    a_wr_held: assert property ($changed(o_wr) |-> o_wr_valid)
        else $error("write word moved without strobe");
endmodule : shci_sva

bind shci_top shci_sva u_shci_sva (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_use_spi(i_use_spi),
    .i_ram_ptr(i_ram_ptr), .i_pwm_ptr(i_pwm_ptr), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_wr_valid(o_wr_valid), .o_wr(o_wr),
    .o_addressed(o_addressed)
);

`default_nettype wire

// ===== tb/shci_host.sv
/*
 * Host model: bit-banged I2C master and SPI master.
 * Assumes the bench resolves the pulled-up data wire into i_sda.
 */
`timescale 1ns/10ps
`default_nettype none

module shci_host (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe,
    output logic o_spi_clk,
    output logic o_spi_cs_n,
    output logic o_serial_in_line
);
    localparam int Q = 100;
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
        o_spi_clk = 1'b0;
        o_spi_cs_n = 1'b1;
        o_serial_in_line = 1'b0;
    end

    // ********************
    // i2c
    // ********************
    // also serves as repeated start
    task automatic start();
        o_sda_oe = 1'b0;
        #Q o_scl = 1'b1;
        #Q o_sda_oe = 1'b1;
        #Q o_scl = 1'b0;
        #Q;
    endtask : start
    task automatic stop();
        o_sda_oe = 1'b1;
        #Q o_scl = 1'b1;
        #Q o_sda_oe = 1'b0;
        #Q;
    endtask : stop
    task automatic pulse(output logic s);
        #Q o_scl = 1'b1;
        s = i_sda;
        #Q o_scl = 1'b0;
        #Q;
    endtask : pulse
    task automatic put(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            o_sda_oe = ~b[i];
            pulse(s);
        end
        o_sda_oe = 1'b0;
        pulse(s);
        ack = ~s;
    endtask : put
    task automatic get(input logic nak, output logic [7:0] b);
        logic s;
        o_sda_oe = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(s);
            b[i] = s;
        end
        o_sda_oe = ~nak;
        pulse(s);
        o_sda_oe = 1'b0;
    endtask : get

    // ********************
    // spi
    // ********************
    task automatic spi(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            o_serial_in_line = b[i];
            #40 o_spi_clk = 1'b1;
            #40 o_spi_clk = 1'b0;
        end
    endtask : spi
    // select idles high between frames, data line scrambled
    task automatic sel(input logic on);
        #43 o_spi_cs_n = ~on;
        o_serial_in_line = ~o_serial_in_line;
        #40;
    endtask : sel
endmodule : shci_host

`default_nettype wire

// ===== tb/testbench.sv
/*
 * Testbench for shci_top: I2C writes and status reads, SPI frames.
 * Assumes shci_host as bus master and shci_sva bound to the top.
 */
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic use_spi = 1'b0;
    logic test_mode = 1'b0;
    logic strap = 1'b0;
    logic [7:0] ram_ptr = 8'h12;
    logic [7:0] pwm_ptr = 8'h34;
    logic scl, m_oe, sda_out, sda_oe, spi_clk, cs_n, ser_in, wr_valid, addressed, ack;
    logic [7:0] rd, exp;
    shci_pkg::wr_t wr;
    shci_pkg::wr_t wr_last = '0;
    int num_errors = 0;
    int num_checks = 0;
    int wr_cnt = 0;
    int cycles = 0;
    // pulled-up open-drain wire
    wire logic sda = ~(m_oe | sda_oe);

    shci_top u_shci_top (
        .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_use_spi(use_spi),
        .i_test_mode(test_mode), .i_address_select_pin(strap), .i_scl(scl),
        .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_spi_clk(spi_clk),
        .i_spi_cs_n(cs_n), .i_serial_in_line(ser_in), .i_ram_ptr(ram_ptr),
        .i_pwm_ptr(pwm_ptr), .o_wr_valid(wr_valid), .o_wr(wr), .o_addressed(addressed)
    );
    shci_host u_shci_host (
        .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe), .o_spi_clk(spi_clk),
        .o_spi_cs_n(cs_n), .o_serial_in_line(ser_in)
    );

    always #5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (wr_valid === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wr_last <= wr;
        end
        if (cycles == 40000) begin
            num_errors = num_errors + 1;
            end_of_test();
        end
    end

    // ********************
    // tasks
    // ********************
    task check(input logic [31:0] seen, input logic [31:0] want);
        num_checks = num_checks + 1;
        if (seen !== want) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task put(input logic [7:0] b, input logic a);
        u_shci_host.put(b, ack);
        check(ack, a);
    endtask : put
    task got(input int n, input shci_pkg::wr_t e);
        check(wr_cnt, n);
        check(wr_last, e);
    endtask : got
    task pins(input logic s, input logic t, input logic u);
        @(posedge i_sys_clk);
        #1;
        strap = s;
        test_mode = t;
        use_spi = u;
        repeat (8) @(posedge i_sys_clk);
        #1;
    endtask : pins
    task frame(input logic [7:0] sub, input logic [7:0] ctl, input logic [7:0] d);
        u_shci_host.sel(1'b1);
        u_shci_host.spi(sub, 8);
        u_shci_host.spi(ctl, 8);
        u_shci_host.spi(d, 8);
        u_shci_host.sel(1'b0);
        repeat (5) @(posedge i_sys_clk);
    endtask : frame
    task end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // ********************
    // tests
    // ********************
    initial begin
        repeat (8) @(posedge i_sys_clk);
        #1 i_nrst = 1'b1;
        repeat (6) @(posedge i_sys_clk);
        #1;
        u_shci_host.start();
        put(8'h70, 1'b1);
        put(8'ha0, 1'b1);
        put(8'h5a, 1'b1);
        got(1, '{shci_pkg::DEST_RAM, 8'h12, 8'h5a});
        put(8'h40, 1'b1);
        put(8'h40, 1'b1);
        got(2, '{shci_pkg::DEST_PWM, 8'h34, 8'h40});
        put(8'h07, 1'b1);
        got(3, '{shci_pkg::DEST_PWM, 8'h34, 8'h07});
        u_shci_host.start();
        put(8'h70, 1'b1);
        put(8'h80, 1'b1);
        put(8'h11, 1'b1);
        got(4, '{shci_pkg::DEST_CMD, 8'h00, 8'h11});
        put(8'h60, 1'b1);
        put(8'h22, 1'b1);
        check(wr_cnt, 4);
        u_shci_host.stop();
        $display("test i2c write done");
        u_shci_host.start();
        put(8'h72, 1'b0);
        put(8'h20, 1'b0);
        check(addressed, 1'b0);
        u_shci_host.start();
        put(8'h70, 1'b1);
        put(8'h20, 1'b1);
        ram_ptr = 8'h56;
        put(8'h3c, 1'b1);
        got(5, '{shci_pkg::DEST_RAM, 8'h56, 8'h3c});
        u_shci_host.stop();
        $display("test i2c select done");
        for (int k = 0; k < 4; k++) begin
            pins(k[0], k[1], 1'b0);
            u_shci_host.start();
            put({shci_pkg::I2C_ADDR_HI, ~strap, 1'b1}, 1'b0);
            u_shci_host.start();
            put({shci_pkg::I2C_ADDR_HI, strap, 1'b1}, 1'b1);
            exp = {k[1] ? shci_pkg::STATUS_TEST : shci_pkg::STATUS_ID, strap};
            u_shci_host.get(1'b0, rd);
            check(rd, exp);
            u_shci_host.get(1'b1, rd);
            check(rd, exp);
            check(sda_oe, 1'b0);
            u_shci_host.stop();
        end
        $display("test status done");
        pins(1'b0, 1'b0, 1'b1);
        u_shci_host.start();
        put(8'h70, 1'b0);
        u_shci_host.stop();
        frame(8'h3f, 8'h20, 8'hc3);
        got(6, '{shci_pkg::DEST_RAM, 8'h56, 8'hc3});
        frame(8'h40, 8'h20, 8'h77);
        frame(8'h60, 8'h20, 8'h77);
        frame(8'ha0, 8'h20, 8'h77);
        check(wr_cnt, 6);
        u_shci_host.sel(1'b1);
        u_shci_host.spi(8'hff, 5);
        u_shci_host.sel(1'b0);
        frame(8'h20, 8'h40, 8'h81);
        got(7, '{shci_pkg::DEST_PWM, 8'h34, 8'h81});
        $display("test spi done");
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
